// *** hw/deac_array.sv ***
// byte-wide nonvolatile array model with single-byte write port
`timescale 1ns/1ps
`default_nettype none
module deac_array #(
	parameter int AW = 10
) (
	input wire logic core_clk,
	input wire logic [AW-1:0] addr,
	input wire logic wr_en,
	input wire logic [7:0] wr_data,
	output logic [7:0] rd_data
);
	logic [7:0] mem [0:(1<<AW)-1];

	// ============================================================
	// one byte per write, content survives reset like a real cell
	always_ff @(posedge core_clk)
	begin
		if (wr_en)
			mem[addr] <= wr_data;
	end
	assign rd_data = mem[addr];
endmodule // deac_array
`default_nettype wire

// *** hw/deac_pkg.sv ***
// package: register map, control fields and timing for the data eeprom access block
package deac_pkg;
	// ============================================================
	// register offsets (own map, one byte register per offset)
	localparam logic [3:0] OFF_ADDR_LO = 4'h0;
	localparam logic [3:0] OFF_ADDR_HI = 4'h1;
	localparam logic [3:0] OFF_DATA = 4'h2;
	localparam logic [3:0] OFF_UNLOCK = 4'h3;
	localparam logic [3:0] OFF_CTRL = 4'h4;
	localparam logic [3:0] OFF_PRIO2 = 4'h5;
	localparam logic [3:0] OFF_FLAGS2 = 4'h6;
	localparam logic [3:0] OFF_ENABLES2 = 4'h7;
	// ============================================================
	// control register fields, plus the completion bit of the flags register
	localparam int CTRL_PGM = 7;
	localparam int CTRL_CFG = 6;
	localparam int CTRL_FREE = 4;
	localparam int CTRL_ERR = 3;
	localparam int CTRL_WEN = 2;
	localparam int CTRL_WR = 1;
	localparam int CTRL_RD = 0;
	localparam int IRQ_DONE_BIT = 4;
	// ============================================================
	// unlock pattern and reset values
	localparam logic [7:0] UNLOCK_FIRST = 8'h55;
	localparam logic [7:0] UNLOCK_SECOND = 8'hAA;
	localparam logic [7:0] RESET_BYTE = 8'h00;
	// ============================================================
	// timing
	localparam int CLK_HZ = 40000000;
	localparam int PWRT_US = 65;
	localparam int PWRT_CYCLES = (PWRT_US * (CLK_HZ / 1000000));
	localparam int WRITE_US = 4000;
	localparam int WRITE_CYCLES = (WRITE_US * (CLK_HZ / 1000000));
	// unlock tracker states
	typedef enum logic [1:0] {DEAC_UL_IDLE, DEAC_UL_GOT55, DEAC_UL_ARMED}
		deac_unlock_t;
endpackage

// *** hw/deac_timer.sv ***
// one-shot down counter used for power-up and self-timed write periods
`timescale 1ns/1ps
`default_nettype none
module deac_timer #(
	parameter int CYCLES = 16
) (
	input wire logic core_clk,
	input wire logic rst,
	input wire logic start,
	output logic busy
);
	logic [31:0] cnt_q;

	// ============================================================
	// counter: start reloads, zero means idle
	always_ff @(posedge core_clk or posedge rst)
	begin
		if (rst)
			cnt_q <= 32'h0;
		else if (start)
			cnt_q <= 32'(CYCLES);
		else if (cnt_q != 32'h0)
			cnt_q <= cnt_q - 32'h1;
	end
	assign busy = (cnt_q != 32'h0);
endmodule // deac_timer
`default_nettype wire

// *** hw/deac_top.sv ***
// data eeprom access control: registers, unlock tracker, write engine
`timescale 1ns/1ps
`default_nettype none
module deac_top #(
	parameter int AW = 10,
	parameter int PWRT_CYC = deac_pkg::PWRT_CYCLES,
	parameter int WRITE_CYC = deac_pkg::WRITE_CYCLES
) (
	input wire logic core_clk,
	input wire logic rst,
	input wire logic [3:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [7:0] reg_rdata,
	input wire logic code_protect,
	input wire logic ext_req,
	input wire logic ext_wr,
	input wire logic [AW-1:0] ext_addr,
	input wire logic [7:0] ext_wdata,
	output logic [7:0] ext_rdata,
	output logic ext_refused,
	output logic irq
);
	logic [7:0] addr_lo_q;
	logic [1:0] addr_hi_q;
	logic [7:0] data_q;
	logic pgm_q, cfg_q, free_q, err_q, wen_q, wr_q, rd_q;
	logic [7:0] prio_q, flags_q, ena_q;
	logic [7:0] rdata_q;
	logic [7:0] ext_rdata_q;
	logic ext_refused_q;
	deac_pkg::deac_unlock_t ul_q;
	logic pwrt_busy, write_busy, write_busy_q, launch, pwrt_start_q;
	logic wr_dirty_q;
	logic [AW-1:0] arr_addr;
	logic arr_we;
	logic [7:0] arr_rdata;
	logic [AW-1:0] cpu_addr;
	logic cpu_sel, ext_ok;
	logic commit, ext_go;

	// ============================================================
	// decode
	function automatic logic hit(input logic [3:0] a, input logic [3:0] o);
		hit = (a == o);
	endfunction

	assign cpu_addr = AW'({addr_hi_q, addr_lo_q});
	assign cpu_sel = !pgm_q && !cfg_q;
	assign ext_ok = ext_req && !code_protect;

	// power-up timer starts once after reset release
	always_ff @(posedge core_clk or posedge rst)
	begin
		if (rst)
			pwrt_start_q <= 1'b1;
		else
			pwrt_start_q <= 1'b0;
	end

	deac_timer #(.CYCLES(PWRT_CYC)) u_pwrt (
		.core_clk(core_clk),
		.rst(rst),
		.start(pwrt_start_q),
		.busy(pwrt_busy)
	);

	// launch: armed tracker, write enable already set, no running timer
	assign launch = reg_wr && hit(reg_addr, deac_pkg::OFF_CTRL)
		&& reg_wdata[deac_pkg::CTRL_WR] && !wr_q && wen_q
		&& (ul_q == deac_pkg::DEAC_UL_ARMED)
		&& !pwrt_busy && cpu_sel;

	deac_timer #(.CYCLES(WRITE_CYC)) u_wtimer (
		.core_clk(core_clk),
		.rst(rst),
		.start(launch),
		.busy(write_busy)
	);

	// ============================================================
	// unlock tracker: any other bus access drops it
	always_ff @(posedge core_clk or posedge rst)
	begin
		if (rst)
			ul_q <= deac_pkg::DEAC_UL_IDLE;
		else if (reg_wr || reg_rd)
		begin
			ul_q <= deac_pkg::DEAC_UL_IDLE;
			if (reg_wr && hit(reg_addr, deac_pkg::OFF_UNLOCK))
			begin
				if (reg_wdata == deac_pkg::UNLOCK_FIRST)
					ul_q <= deac_pkg::DEAC_UL_GOT55;
				else if (reg_wdata == deac_pkg::UNLOCK_SECOND
					&& ul_q == deac_pkg::DEAC_UL_GOT55)
					ul_q <= deac_pkg::DEAC_UL_ARMED;
			end
		end
	end

	// ============================================================
	// address and data registers, frozen during a write except when the launching control write also sets the read bit
	always_ff @(posedge core_clk or posedge rst)
	begin
		if (rst)
		begin
			addr_lo_q <= deac_pkg::RESET_BYTE;
			addr_hi_q <= 2'h0;
		end
		else if (reg_wr && !wr_q)
		begin
			if (hit(reg_addr, deac_pkg::OFF_ADDR_LO))
				addr_lo_q <= reg_wdata;
			if (hit(reg_addr, deac_pkg::OFF_ADDR_HI))
				addr_hi_q <= reg_wdata[1:0];
		end
	end

	// data: software write or read completion fills it
	always_ff @(posedge core_clk or posedge rst)
	begin
		if (rst)
			data_q <= deac_pkg::RESET_BYTE;
		else if (rd_q)
			data_q <= arr_rdata;
		else if (reg_wr && !wr_q && hit(reg_addr, deac_pkg::OFF_DATA))
			data_q <= reg_wdata;
	end

	// ============================================================
	// control register; unlock port has no storage at all
	always_ff @(posedge core_clk or posedge rst)
	begin
		if (rst)
		begin
			pgm_q <= 1'b0;
			cfg_q <= 1'b0;
			free_q <= 1'b0;
			wen_q <= 1'b0;
			wr_q <= 1'b0;
			rd_q <= 1'b0;
		end
		else
		begin
			rd_q <= 1'b0;
			if (wr_q && !write_busy)
				wr_q <= 1'b0;
			if (launch)
				wr_q <= 1'b1;
			if (reg_wr && !wr_q && hit(reg_addr, deac_pkg::OFF_CTRL))
			begin
				pgm_q <= reg_wdata[deac_pkg::CTRL_PGM];
				cfg_q <= reg_wdata[deac_pkg::CTRL_CFG];
				free_q <= reg_wdata[deac_pkg::CTRL_FREE];
				wen_q <= reg_wdata[deac_pkg::CTRL_WEN];
				rd_q <= reg_wdata[deac_pkg::CTRL_RD] && cpu_sel
					&& !reg_wdata[deac_pkg::CTRL_PGM]
					&& !reg_wdata[deac_pkg::CTRL_CFG];
			end
		end
	end

	// error flag: a write cut by reset leaves a dirty marker behind
	// the marker freezes while reset is high and has no reset of its own
	always_ff @(posedge core_clk)
	begin
		if (!rst)
			wr_dirty_q <= wr_q;
	end

	always_ff @(posedge core_clk or posedge rst)
	begin
		if (rst)
			write_busy_q <= 1'b0;
		else
			write_busy_q <= write_busy;
	end

	// error flag: captured at the first clock after release; hw set wins
	always_ff @(posedge core_clk or posedge rst)
	begin
		if (rst)
			err_q <= 1'b0;
		else if (pwrt_start_q && wr_dirty_q === 1'b1)
			err_q <= 1'b1;
		else if (reg_wr && !wr_q && hit(reg_addr, deac_pkg::OFF_CTRL))
			err_q <= reg_wdata[deac_pkg::CTRL_ERR];
	end

	// ============================================================
	// array port: cpu always allowed, external only when unprotected
	// cpu commit and read own the port; an external access that lands in
	// such a cycle is dropped and the programmer has to retry it
	assign commit = wr_q && write_busy_q && !write_busy;
	assign ext_go = ext_ok && !commit && !rd_q;
	assign arr_addr = ext_go ? ext_addr : cpu_addr;
	assign arr_we = commit || (ext_go && ext_wr && !wr_q);

	deac_array #(.AW(AW)) u_array (
		.core_clk(core_clk),
		.addr(arr_addr),
		.wr_en(arr_we),
		.wr_data(commit ? data_q : ext_wdata),
		.rd_data(arr_rdata)
	);

	// external port answer
	always_ff @(posedge core_clk or posedge rst)
	begin
		if (rst)
		begin
			ext_rdata_q <= deac_pkg::RESET_BYTE;
			ext_refused_q <= 1'b0;
		end
		else
		begin
			ext_refused_q <= ext_req && code_protect;
			if (ext_go && !ext_wr)
				ext_rdata_q <= arr_rdata;
		end
	end
	assign ext_rdata = ext_rdata_q;
	assign ext_refused = ext_refused_q;

	// ============================================================
	// interrupt registers; completion set wins over software clear
	always_ff @(posedge core_clk or posedge rst)
	begin
		if (rst)
		begin
			flags_q <= deac_pkg::RESET_BYTE;
			ena_q <= deac_pkg::RESET_BYTE;
			prio_q <= deac_pkg::RESET_BYTE;
		end
		else
		begin
			if (reg_wr && hit(reg_addr, deac_pkg::OFF_FLAGS2))
				flags_q <= flags_q & ~reg_wdata;
			if (wr_q && !write_busy)
				flags_q[deac_pkg::IRQ_DONE_BIT] <= 1'b1;
			if (reg_wr && hit(reg_addr, deac_pkg::OFF_ENABLES2))
				ena_q <= reg_wdata;
			if (reg_wr && hit(reg_addr, deac_pkg::OFF_PRIO2))
				prio_q <= reg_wdata;
		end
	end
	assign irq = |(flags_q & ena_q);

	// ============================================================
	// read mux, data one cycle after the strobe
	always_ff @(posedge core_clk or posedge rst)
	begin
		if (rst)
			rdata_q <= deac_pkg::RESET_BYTE;
		else if (reg_rd)
		begin
			unique case (reg_addr)
				deac_pkg::OFF_ADDR_LO: rdata_q <= addr_lo_q;
				deac_pkg::OFF_ADDR_HI: rdata_q <= {6'h00, addr_hi_q};
				deac_pkg::OFF_DATA: rdata_q <= data_q;
				deac_pkg::OFF_CTRL: rdata_q <= {pgm_q, cfg_q, 1'b0, free_q,
					err_q, wen_q, wr_q, rd_q};
				deac_pkg::OFF_PRIO2: rdata_q <= prio_q;
				deac_pkg::OFF_FLAGS2: rdata_q <= flags_q;
				deac_pkg::OFF_ENABLES2: rdata_q <= ena_q;
				default: rdata_q <= deac_pkg::RESET_BYTE;
			endcase
		end
		else
			rdata_q <= deac_pkg::RESET_BYTE;
	end
	assign reg_rdata = rdata_q;

	// ============================================================
	// checks
	wen_reset_a: assert property (@(posedge core_clk)
		$fell(rst) |-> !wen_q)
		else $error("write enable not clear after reset");
	wr_needs_arm_a: assert property (@(posedge core_clk) disable iff (rst)
		$rose(wr_q) |-> $past(ul_q) == deac_pkg::DEAC_UL_ARMED)
		else $error("write launched without unlock");
	wr_needs_wen_a: assert property (@(posedge core_clk) disable iff (rst)
		$rose(wr_q) |-> $past(wen_q))
		else $error("write launched without prior enable");
	rd_selfclr_a: assert property (@(posedge core_clk) disable iff (rst)
		rd_q |=> !rd_q)
		else $error("read bit did not clear");
	pwrt_block_a: assert property (@(posedge core_clk) disable iff (rst)
		pwrt_busy |=> !$rose(wr_q))
		else $error("write during power-up timer");
	addr_lock_a: assert property (@(posedge core_clk) disable iff (rst)
		wr_q && $past(wr_q) |-> $stable(addr_lo_q) && $stable(data_q))
		else $error("registers changed during write");
	done_flag_a: assert property (@(posedge core_clk) disable iff (rst)
		$fell(wr_q) |-> flags_q[deac_pkg::IRQ_DONE_BIT])
		else $error("completion flag not set");
	ext_refuse_a: assert property (@(posedge core_clk) disable iff (rst)
		ext_req && code_protect |-> !arr_we || wr_q)
		else $error("protected external write reached array");
	wr_hold_a: assert property (@(posedge core_clk)
		disable iff (rst) wr_q && write_busy |=> wr_q)
		else $error("write bit dropped while timer busy");
	rd_fill_a: assert property (@(posedge core_clk)
		disable iff (rst) rd_q |=> data_q == $past(arr_rdata))
		else $error("read did not load data register");
	rd_select_a: assert property (@(posedge core_clk)
		disable iff (rst) rd_q |-> !pgm_q && !cfg_q)
		else $error("read started with a select bit set");
	err_abort_a: assert property (@(posedge core_clk)
		!rst && pwrt_start_q && wr_dirty_q |=> err_q)
		else $error("aborted write left no error flag");
	unlock_drop_a: assert property (@(posedge core_clk)
		disable iff (rst)
		reg_rd || (reg_wr && reg_addr != deac_pkg::OFF_UNLOCK)
		|=> ul_q == deac_pkg::DEAC_UL_IDLE)
		else $error("unlock tracker kept state after other access");
	unlock_blank_a: assert property (@(posedge core_clk)
		disable iff (rst) reg_rd && reg_addr == deac_pkg::OFF_UNLOCK
		|=> reg_rdata == deac_pkg::RESET_BYTE)
		else $error("unlock port read back a value");
	ctrl_lock_a: assert property (@(posedge core_clk)
		disable iff (rst)
		wr_q && $past(wr_q) |-> $stable(wen_q) && $stable(addr_hi_q))
		else $error("control changed during write");
	ext_flag_a: assert property (@(posedge core_clk)
		disable iff (rst) ext_req && code_protect |=> ext_refused)
		else $error("protected external access not flagged");
endmodule // deac_top
`default_nettype wire

// *** testbench/data_eeprom_access_control_test.sv ***
// self-checking bench for the data eeprom access block
`timescale 1ns/1ps
`default_nettype none
module data_eeprom_access_control_test;
	// ============================================================
	// signals
	logic core_clk = 1'b0;
	logic rst = 1'b1;
	logic [3:0] reg_addr = 4'h0;
	logic [7:0] reg_wdata = 8'h00;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic code_protect = 1'b0;
	logic [7:0] reg_rdata, ext_wdata, ext_rdata, v;
	logic [9:0] ext_addr;
	logic ext_req, ext_wr, ext_refused, irq;
	int mismatches = 0;
	int tests_run = 0;
	int i;
	logic [7:0] pre_c [3] = '{8'h00, 8'h84, 8'h44};
	logic [7:0] bad_c [3] = '{8'h06, 8'h86, 8'h46};
	// ============================================================
	// design, programmer model and clock
	deac_top #(.AW(10), .PWRT_CYC(8), .WRITE_CYC(20)) dut (
		.core_clk(core_clk), .rst(rst), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_rdata(reg_rdata), .code_protect(code_protect),
		.ext_req(ext_req), .ext_wr(ext_wr), .ext_addr(ext_addr),
		.ext_wdata(ext_wdata), .ext_rdata(ext_rdata),
		.ext_refused(ext_refused), .irq(irq));
	deac_ext_prog prog (.core_clk(core_clk), .ext_req(ext_req),
		.ext_wr(ext_wr), .ext_addr(ext_addr), .ext_wdata(ext_wdata));
	always #12.5 core_clk = ~core_clk;
	// ============================================================
	// bus tasks: strobes held to the taking edge, writes may chain
	task automatic wr(input logic [3:0] a, input logic [7:0] d);
	begin
		reg_addr <= a;
		reg_wdata <= d;
		reg_rd <= 1'b0;
		reg_wr <= 1'b1;
		@(posedge core_clk);
	end
	endtask
	task automatic idle();
	begin
		reg_wr <= 1'b0;
		reg_rd <= 1'b0;
		@(posedge core_clk);
		#1;
	end
	endtask
	// read data stands only in the cycle after the strobe
	task automatic rd(input logic [3:0] a);
	begin
		reg_addr <= a;
		reg_wr <= 1'b0;
		reg_rd <= 1'b1;
		@(posedge core_clk);
		reg_rd <= 1'b0;
		#1 v = reg_rdata;
	end
	endtask
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
	begin
		tests_run++;
		if (got !== exp)
		begin
			mismatches++;
			$display("BAD t=%0t got %h want %h", $time, got, exp);
		end
	end
	endtask
	// full unlock sequence, strictly back to back, nothing cuts in
	task automatic ee_write(input logic [9:0] a, input logic [7:0] d);
	begin
		wr(deac_pkg::OFF_ADDR_LO, a[7:0]);
		wr(deac_pkg::OFF_ADDR_HI, {6'h00, a[9:8]});
		wr(deac_pkg::OFF_DATA, d);
		wr(deac_pkg::OFF_CTRL, 8'h04);
		wr(deac_pkg::OFF_UNLOCK, deac_pkg::UNLOCK_FIRST);
		wr(deac_pkg::OFF_UNLOCK, deac_pkg::UNLOCK_SECOND);
		wr(deac_pkg::OFF_CTRL, 8'h06);
		idle();
	end
	endtask
	task automatic ee_read(input logic [9:0] a);
	begin
		wr(deac_pkg::OFF_ADDR_LO, a[7:0]);
		wr(deac_pkg::OFF_ADDR_HI, {6'h00, a[9:8]});
		wr(deac_pkg::OFF_CTRL, 8'h01);
		idle();
		rd(deac_pkg::OFF_DATA);
	end
	endtask
	// polling is bounded so a stuck busy bit cannot hang the run
	task automatic wait_done();
	begin
		for (i = 0; i < 40; i++)
		begin
			rd(deac_pkg::OFF_CTRL);
			if (v[1] === 1'b0)
				break;
		end
		chk(v, 8'h04);
	end
	endtask
	task automatic end_sim();
	begin
		$display("mismatches %0d tests_run %0d", mismatches, tests_run);
		if (mismatches == 0 && tests_run > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	end
	endtask
	// ============================================================
	// watchdog, well over ten times the expected run length
	initial
	begin
		#75000;
		mismatches++;
		end_sim();
	end
	// ============================================================
	// test sequence
	initial
	begin
		repeat (12) @(posedge core_clk);
		rst <= 1'b0;
		rd(deac_pkg::OFF_CTRL);
		chk(v, 8'h00);
		wr(deac_pkg::OFF_CTRL, 8'h24);
		wr(deac_pkg::OFF_UNLOCK, deac_pkg::UNLOCK_FIRST);
		wr(deac_pkg::OFF_UNLOCK, deac_pkg::UNLOCK_SECOND);
		wr(deac_pkg::OFF_CTRL, 8'h26);
		idle();
		rd(deac_pkg::OFF_CTRL);
		chk(v, 8'h04);
		rd(deac_pkg::OFF_UNLOCK);
		chk(v, 8'h00);
		rd(4'hF);
		chk(v, 8'h00);
		repeat (10) @(posedge core_clk);
		$display("test power-up done");
		ee_write(10'h112, 8'h5A);
		rd(deac_pkg::OFF_CTRL);
		chk(v[1], 1'b1);
		rd(deac_pkg::OFF_FLAGS2);
		chk(v, 8'h00);
		// changes while busy must be dropped
		wr(deac_pkg::OFF_DATA, 8'hFF);
		wr(deac_pkg::OFF_ADDR_LO, 8'h00);
		wr(deac_pkg::OFF_CTRL, 8'h00);
		idle();
		wait_done();
		rd(deac_pkg::OFF_DATA);
		chk(v, 8'h5A);
		rd(deac_pkg::OFF_ADDR_LO);
		chk(v, 8'h12);
		rd(deac_pkg::OFF_FLAGS2);
		chk(v, 8'h10);
		chk(irq, 1'b0);
		wr(deac_pkg::OFF_ENABLES2, 8'h10);
		idle();
		chk(irq, 1'b1);
		wr(deac_pkg::OFF_ENABLES2, 8'h00);
		idle();
		chk(irq, 1'b0);
		wr(deac_pkg::OFF_ENABLES2, 8'h10);
		wr(deac_pkg::OFF_FLAGS2, 8'h10);
		idle();
		rd(deac_pkg::OFF_FLAGS2);
		chk({v[7:1], irq}, 8'h00);
		$display("test write and irq done");
		// neighbour differing only in the high address bits
		ee_write(10'h012, 8'hA5);
		wait_done();
		ee_read(10'h112);
		chk(v, 8'h5A);
		ee_read(10'h012);
		chk(v, 8'hA5);
		rd(deac_pkg::OFF_CTRL);
		chk(v, 8'h00);
		$display("test addressing done");
		// refused launches: no prior enable, program or config selected
		for (int k = 0; k < 3; k++)
		begin
			wr(deac_pkg::OFF_CTRL, pre_c[k]);
			wr(deac_pkg::OFF_UNLOCK, deac_pkg::UNLOCK_FIRST);
			wr(deac_pkg::OFF_UNLOCK, deac_pkg::UNLOCK_SECOND);
			wr(deac_pkg::OFF_CTRL, bad_c[k]);
			idle();
			rd(deac_pkg::OFF_CTRL);
			chk(v[1], 1'b0);
		end
		wr(deac_pkg::OFF_CTRL, 8'h04);
		wr(deac_pkg::OFF_UNLOCK, deac_pkg::UNLOCK_FIRST);
		rd(deac_pkg::OFF_DATA);
		wr(deac_pkg::OFF_UNLOCK, deac_pkg::UNLOCK_SECOND);
		wr(deac_pkg::OFF_CTRL, 8'h06);
		idle();
		rd(deac_pkg::OFF_CTRL);
		chk(v[1], 1'b0);
		$display("test refused launch done");
		code_protect <= 1'b1;
		prog.access(1'b0, 10'h112, 8'h00);
		#1 chk(ext_refused, 1'b1);
		prog.access(1'b1, 10'h012, 8'h00);
		#1 chk(ext_refused, 1'b1);
		ee_read(10'h012);
		chk(v, 8'hA5);
		code_protect <= 1'b0;
		prog.access(1'b0, 10'h112, 8'h00);
		#1 chk({ext_refused, 7'h00}, 8'h00);
		chk(ext_rdata, 8'h5A);
		$display("test code protect done");
		// reset in the middle of a timed write
		ee_write(10'h001, 8'h77);
		repeat (3) @(posedge core_clk);
		rst <= 1'b1;
		repeat (2) @(posedge core_clk);
		rst <= 1'b0;
		// error flag is captured at the first edge after release
		idle();
		rd(deac_pkg::OFF_CTRL);
		chk(v, 8'h08);
		$display("test aborted write done");
		end_sim();
	end
endmodule // data_eeprom_access_control_test
`default_nettype wire

// *** testbench/deac_ext_prog.sv ***
// external programmer model driving the off-chip access port
`timescale 1ns/1ps
`default_nettype none
module deac_ext_prog (
	input wire logic core_clk,
	output logic ext_req,
	output logic ext_wr,
	output logic [9:0] ext_addr,
	output logic [7:0] ext_wdata
);
	// quiet port at time zero
	initial
	begin
		ext_req = 1'b0;
		ext_wr = 1'b0;
		ext_addr = 10'h000;
		ext_wdata = 8'h00;
	end
	// one-cycle request; released lines show the inverse, not a stale copy
	task automatic access(input logic w, input logic [9:0] a,
		input logic [7:0] d);
	begin
		@(posedge core_clk);
		ext_req <= 1'b1;
		ext_wr <= w;
		ext_addr <= a;
		ext_wdata <= d;
		@(posedge core_clk);
		ext_req <= 1'b0;
		ext_wr <= 1'b0;
		ext_addr <= ~a;
		ext_wdata <= ~d;
	end
	endtask
endmodule // deac_ext_prog
`default_nettype wire
